//--- verilog/lec_pkg.sv
/*
 * Constants for the link enhancement control block: offsets, field positions,
 * reset value, writable mask and the asynchronous transmit thresholds.
 * Assumes byte addresses on the memory-mapped port and a 32-bit control word.
 */
package lec_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [11:0] LEC_OFS_SET = 12'hA88;
   localparam logic [11:0] LEC_OFS_CLR = 12'hA8C;
   localparam logic [7:0] LEC_CFG_OFS = 8'hF4;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int LEC_BIT_PIPE_OFF = 15;
   localparam int LEC_BIT_THR_HI = 13;
   localparam int LEC_BIT_THR_LO = 12;
   localparam int LEC_BIT_TS_STAMP = 10;
   localparam int LEC_BIT_VID_STAMP = 8;
   localparam int LEC_BIT_PRIO_ARB = 7;
   localparam int LEC_BIT_ACCEL = 1;

   // ****************************************************************
   // Reset value and masks
   // ****************************************************************
   localparam logic [31:0] LEC_RESET_VAL = 32'h0000_1000;
   localparam logic [31:0] LEC_WR_MASK = 32'h0000_B582;
   localparam logic [31:0] LEC_EE_MASK = 32'h0000_B582;

   // ****************************************************************
   // Stream format codes
   // ****************************************************************
   localparam logic [7:0] LEC_FMT_TS = 8'h20;
   localparam logic [7:0] LEC_FMT_VIDEO = 8'h00;

   // ****************************************************************
   // Transmit threshold codes and byte counts
   // ****************************************************************
   typedef enum logic [1:0] {
      LEC_THR_2K = 2'h0,
      LEC_THR_1K7 = 2'h1,
      LEC_THR_1K = 2'h2,
      LEC_THR_512 = 2'h3
   } lec_thr_t;

   localparam logic [11:0] LEC_BYTES_2K = 12'h800;
   localparam logic [11:0] LEC_BYTES_1K7 = 12'h6C0;
   localparam logic [11:0] LEC_BYTES_1K = 12'h400;
   localparam logic [11:0] LEC_BYTES_512 = 12'h200;

endpackage

//--- verilog/lec_strm_if.sv
/*
 * Word stream carrier used between the block's own modules.
 * Assumes one clock; a word moves when valid and ready are both high.
 */
`timescale 1ns/1ps
interface lec_strm_if #(parameter int DATA_W = 32);
   logic valid;
   logic ready;
   logic last;
   logic [DATA_W-1:0] data;

   modport src (output valid, output last, output data, input ready);
   modport snk (input valid, input last, input data, output ready);
endinterface

//--- verilog/lec_skid.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and synchronous active-high reset; full and empty are exact.
 */
`timescale 1ns/1ps
module lec_skid
   import lec_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   lec_strm_if.snk up,
   lec_strm_if.src dn
);

   if (DATA_W < 1)
   begin : g_bad_width
      $error("DATA_W must be at least 1");
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [DATA_W:0] mem_q [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;
   logic [1:0] cnt_d;
   logic rdy_q;

   // Handshakes on both sides
   assign push = up.valid && up.ready;
   assign pop = dn.valid && dn.ready;
   assign up.ready = rdy_q;
   assign dn.valid = (cnt_q != 2'h0);
   assign dn.data = mem_q[rd_ptr_q][DATA_W-1:0];
   assign dn.last = mem_q[rd_ptr_q][DATA_W];

   // Fill level after this edge's moves
   assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   // Entry writes
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= {up.last, up.data};
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
         rdy_q <= 1'b1;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != 2'h2); // Ready from a flop, same timing as the fill level
      end
   end

endmodule

//--- verilog/lec_tx_gate.sv
/*
 * Start decision for the asynchronous transmit path: fill threshold,
 * end-of-packet, and fall-back to store-and-forward.
 * Assumes word accept pulses from the buffer output and a tx_done pulse per packet.
 */
`timescale 1ns/1ps
module lec_tx_gate
   import lec_pkg::*;
#(
   parameter int WORD_BYTES = 4
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [1:0] thr_sel,
   input wire logic word_acc,
   input wire logic word_last,
   input wire logic underrun,
   input wire logic retry_pkt,
   input wire logic retries_zero,
   input wire logic tx_done,
   output logic tx_start,
   output logic store_fwd
);

   if (WORD_BYTES < 1 || WORD_BYTES > 256)
   begin : g_bad_step
      $error("WORD_BYTES must be from 1 to 256");
   end

   localparam logic [11:0] STEP = 12'(WORD_BYTES);

   logic [11:0] cnt_q;
   logic eop_q;
   logic fallback_q;
   logic [11:0] thr_bytes;
   logic sf_now;

   // Byte threshold from the field
   always_comb
   begin
      unique case (lec_thr_t'(thr_sel))
         LEC_THR_2K: thr_bytes = LEC_BYTES_2K;
         LEC_THR_1K7: thr_bytes = LEC_BYTES_1K7;
         LEC_THR_1K: thr_bytes = LEC_BYTES_1K;
         LEC_THR_512: thr_bytes = LEC_BYTES_512;
      endcase
   end

   // Store-and-forward forced by field, underrun, retry or zero retries
   assign sf_now = (thr_sel == LEC_THR_2K) || fallback_q || retry_pkt || retries_zero;

   // Underrun latch: set wins over the end-of-packet clear
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         fallback_q <= 1'b0;
      end
      else if (underrun)
      begin
         fallback_q <= 1'b1;
      end
      else if (tx_done)
      begin
         fallback_q <= 1'b0;
      end
   end

   // Fill count and end-of-packet token of the packet being assembled
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cnt_q <= 12'h000;
         eop_q <= 1'b0;
      end
      else if (tx_done)
      begin
         cnt_q <= word_acc ? STEP : 12'h000;
         eop_q <= word_acc && word_last;
      end
      else if (word_acc)
      begin
         cnt_q <= (cnt_q >= LEC_BYTES_2K - STEP) ? LEC_BYTES_2K : cnt_q + STEP;
         eop_q <= eop_q || word_last;
      end
   end

   // Start when whole packet is in, or fill reaches threshold while store-and-forward is off
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tx_start <= 1'b0;
         store_fwd <= 1'b1;
      end
      else
      begin
         tx_start <= !tx_done && (eop_q || (!sf_now && cnt_q >= thr_bytes));
         store_fwd <= sf_now;
      end
   end

endmodule

//--- verilog/lec_link_enh.sv
/*
 * Link enhancement control word with set/clear memory-mapped offsets,
 * a configuration-space alias, EEPROM load, and the transmit controls it steers.
 * Assumes synchronous single-cycle strobes on the host, config and EEPROM ports.
 */
`timescale 1ns/1ps
module lec_link_enh
   import lec_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [11:0] mm_addr,
   input wire logic mm_wr,
   input wire logic mm_rd,
   input wire logic [31:0] mm_wdata,
   output logic [31:0] mm_rdata,
   output logic mm_rvalid,
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic ee_present,
   input wire logic ee_load,
   input wire logic [15:0] ee_data,
   input wire logic [7:0] stream_format_code,
   output logic transport_stream_stamp_on,
   output logic video_cip_stamp_on,
   output logic async_tx_pipeline_off,
   output logic priority_arb_on,
   output logic phy_accel_notify,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic s_last,
   input wire logic [DATA_W-1:0] s_data,
   output logic m_valid,
   input wire logic m_ready,
   output logic m_last,
   output logic [DATA_W-1:0] m_data,
   input wire logic underrun,
   input wire logic retry_pkt,
   input wire logic retries_zero,
   input wire logic tx_done,
   output logic tx_start,
   output logic store_fwd
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (DATA_W < 8 || DATA_W % 8 != 0 || DATA_W > 256)
   begin : g_bad_width
      $error("DATA_W must be a multiple of 8 from 8 to 256");
   end

   // Package fields must fill the writable mask exactly
   localparam logic [31:0] FIELD_BITS = (32'h1 << LEC_BIT_PIPE_OFF) | (32'h1 << LEC_BIT_THR_HI)
      | (32'h1 << LEC_BIT_THR_LO) | (32'h1 << LEC_BIT_TS_STAMP) | (32'h1 << LEC_BIT_VID_STAMP)
      | (32'h1 << LEC_BIT_PRIO_ARB) | (32'h1 << LEC_BIT_ACCEL);

   if (FIELD_BITS != LEC_WR_MASK)
   begin : g_bad_mask
      $error("Writable mask must match the field positions");
   end

   if ((LEC_EE_MASK & ~LEC_WR_MASK) != 32'h0000_0000)
   begin : g_bad_ee_mask
      $error("EEPROM mask may only cover writable bits");
   end

   if ((LEC_RESET_VAL & ~LEC_WR_MASK) != 32'h0000_0000)
   begin : g_bad_reset
      $error("Reset value may only set writable bits");
   end

   if (LEC_BIT_THR_HI != LEC_BIT_THR_LO + 1)
   begin : g_bad_thr
      $error("Threshold field must be two adjacent bits");
   end

   if (LEC_OFS_SET[1:0] != 2'h0 || LEC_OFS_CLR[1:0] != 2'h0 || LEC_OFS_SET == LEC_OFS_CLR)
   begin : g_bad_ofs
      $error("Set and clear offsets must be distinct word addresses");
   end

   // ****************************************************************
   // Control word
   // ****************************************************************
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic hit_set;
   logic hit_clr;
   logic hit_cfg;
   logic wr_set;
   logic wr_clr;
   logic wr_cfg;
   logic wr_ee;
   logic fmt_is_ts;
   logic fmt_is_video;
   logic [31:0] rd_word;

   // Address decode of the three access paths
   assign hit_set = (mm_addr == LEC_OFS_SET);
   assign hit_clr = (mm_addr == LEC_OFS_CLR);
   assign hit_cfg = (cfg_addr == LEC_CFG_OFS);

   // Write strobes per access path
   assign wr_set = mm_wr && hit_set;
   assign wr_clr = mm_wr && hit_clr;
   assign wr_cfg = cfg_wr && hit_cfg;
   assign wr_ee = ee_present && ee_load;

   // Format code compare for the two stamp kinds
   assign fmt_is_ts = (stream_format_code == LEC_FMT_TS);
   assign fmt_is_video = (stream_format_code == LEC_FMT_VIDEO);

   // Visible word; unstored positions always read zero
   assign rd_word = word_q & LEC_WR_MASK;

   // Next value: EEPROM over config over set/clear; only writable bits move
   always_comb
   begin
      word_d = word_q;
      if (wr_set)
      begin
         word_d = word_q | (mm_wdata & LEC_WR_MASK);
      end
      else if (wr_clr)
      begin
         word_d = word_q & ~(mm_wdata & LEC_WR_MASK);
      end
      if (wr_cfg)
      begin
         word_d = cfg_wdata & LEC_WR_MASK;
      end
      if (wr_ee)
      begin
         word_d = (word_d & ~LEC_EE_MASK) | ({16'h0000, ee_data} & LEC_EE_MASK);
      end
   end

   // Control word register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         word_q <= LEC_RESET_VAL;
      end
      else
      begin
         word_q <= word_d;
      end
   end

   // ****************************************************************
   // Read paths
   // ****************************************************************

   // Memory-mapped reads at either offset return the word; others read zero
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         mm_rdata <= 32'h0000_0000;
         mm_rvalid <= 1'b0;
      end
      else
      begin
         mm_rvalid <= mm_rd;
         mm_rdata <= (mm_rd && (hit_set || hit_clr)) ? rd_word : 32'h0000_0000;
      end
   end

   // Configuration-space alias read
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_rd;
         cfg_rdata <= (cfg_rd && hit_cfg) ? rd_word : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Steered controls
   // ****************************************************************

   // Link controls straight from the word
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         async_tx_pipeline_off <= 1'b0;
         priority_arb_on <= 1'b0;
         phy_accel_notify <= 1'b0;
      end
      else
      begin
         async_tx_pipeline_off <= word_q[LEC_BIT_PIPE_OFF];
         priority_arb_on <= word_q[LEC_BIT_PRIO_ARB];
         phy_accel_notify <= word_q[LEC_BIT_ACCEL];
      end
   end

   // Stream stamps only for their own format code
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         transport_stream_stamp_on <= 1'b0;
         video_cip_stamp_on <= 1'b0;
      end
      else
      begin
         transport_stream_stamp_on <= word_q[LEC_BIT_TS_STAMP] && fmt_is_ts;
         video_cip_stamp_on <= word_q[LEC_BIT_VID_STAMP] && fmt_is_video;
      end
   end

   // ****************************************************************
   // Transmit data path
   // ****************************************************************
   lec_strm_if #(.DATA_W(DATA_W)) in_if ();
   lec_strm_if #(.DATA_W(DATA_W)) out_if ();
   logic hold_valid_q;
   logic hold_last_q;
   logic [DATA_W-1:0] hold_data_q;

   // Input stream onto the buffer's carrier
   assign in_if.valid = s_valid;
   assign in_if.last = s_last;
   assign in_if.data = s_data;
   assign s_ready = in_if.ready;

   // Buffer between host words and the transmit FIFO
   lec_skid #(.DATA_W(DATA_W)) u_skid (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .up(in_if.snk),
      .dn(out_if.src)
   );

   // Output register stage; takes a word only when it is empty or drained
   assign out_if.ready = !hold_valid_q || m_ready;

   // Output word register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         hold_valid_q <= 1'b0;
         hold_last_q <= 1'b0;
         hold_data_q <= '0;
      end
      else if (out_if.ready)
      begin
         hold_valid_q <= out_if.valid;
         hold_last_q <= out_if.last;
         hold_data_q <= out_if.data;
      end
   end

   // Output stream straight from the hold registers
   assign m_valid = hold_valid_q;
   assign m_last = hold_last_q;
   assign m_data = hold_data_q;

   // Transmit start decision from the programmed threshold
   lec_tx_gate #(.WORD_BYTES(DATA_W / 8)) u_gate (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .thr_sel(word_q[LEC_BIT_THR_HI:LEC_BIT_THR_LO]),
      .word_acc(m_valid && m_ready),
      .word_last(m_last),
      .underrun(underrun),
      .retry_pkt(retry_pkt),
      .retries_zero(retries_zero),
      .tx_done(tx_done),
      .tx_start(tx_start),
      .store_fwd(store_fwd)
   );

endmodule

//--- verif/lec_link_enh_props.sv
/* Port checker for lec_link_enh.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module lec_link_enh_chk
   import lec_pkg::*;
#(
   parameter int DATA_W = 32
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [11:0] mm_addr,
   input wire logic mm_wr,
   input wire logic mm_rd,
   input wire logic [31:0] mm_wdata,
   input wire logic [31:0] mm_rdata,
   input wire logic mm_rvalid,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic ee_load,
   input wire logic [7:0] stream_format_code,
   input wire logic transport_stream_stamp_on,
   input wire logic video_cip_stamp_on,
   input wire logic async_tx_pipeline_off,
   input wire logic phy_accel_notify,
   input wire logic m_valid,
   input wire logic m_ready,
   input wire logic m_last,
   input wire logic [DATA_W-1:0] m_data,
   input wire logic underrun,
   input wire logic retries_zero,
   input wire logic store_fwd
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Lone set or clear writes, no other write path that cycle
   sequence s_set_pipe;
      mm_wr && mm_addr == 12'hA88 && mm_wdata[15] && !cfg_wr && !ee_load;
   endsequence
   sequence s_clr_accel;
      mm_wr && mm_addr == 12'hA8C && mm_wdata[1] && !cfg_wr && !ee_load;
   endsequence

   a_rd_answer: assert property (mm_rd |=> mm_rvalid)
      else $error("read without answer");
   a_cfg_answer: assert property (cfg_rd |=> cfg_rvalid)
      else $error("config read without answer");
   a_rd_reserved: assert property (mm_rvalid |-> (mm_rdata & 32'hFFFF_4A7D) == 32'h0)
      else $error("reserved bit read as one");
   a_cfg_reserved: assert property (cfg_rvalid |-> (cfg_rdata & 32'hFFFF_4A7D) == 32'h0)
      else $error("reserved config bit read as one");
   a_set_pipe: assert property (s_set_pipe |-> ##2 async_tx_pipeline_off)
      else $error("set did not reach pipeline control");
   a_clr_accel: assert property (s_clr_accel |-> ##2 !phy_accel_notify)
      else $error("clear did not reach accel notify");
   a_ts_format: assert property (transport_stream_stamp_on |-> $past(stream_format_code) == 8'h20)
      else $error("stream stamp on wrong format");
   a_vid_format: assert property (video_cip_stamp_on |-> $past(stream_format_code) == 8'h00)
      else $error("video stamp on wrong format");
   a_sf_retries: assert property (retries_zero |=> store_fwd)
      else $error("no store-forward with zero retries");
   a_sf_underrun: assert property (underrun |-> ##2 store_fwd)
      else $error("no store-forward after underrun");
   a_out_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data) && $stable(m_last))
      else $error("output word dropped while stalled");
endmodule

bind lec_link_enh lec_link_enh_chk #(.DATA_W(DATA_W)) u_chk (.*);

//--- verif/lec_sink.sv
/* Receiver model for the output word stream.
   Ready is withheld while stall is high; accepted words are counted. */
`timescale 1ns/1ps
module lec_sink
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic m_valid,
   output logic m_ready,
   output int n_words
);
   // Registered ready, so a stall bites one edge later
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         m_ready <= 1'b0;
      else
         m_ready <= !stall;
   end

   // Count each word taken
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         n_words <= 0;
      else if (m_valid && m_ready)
         n_words <= n_words + 1;
   end
endmodule

//--- verif/testbench.sv
/* Bench for lec_link_enh: registers, stamps, EEPROM load, transmit start.
   Inputs change 1 ns after the rising edge; lec_sink drains the output. */
`timescale 1ns/1ps
module testbench
   import lec_pkg::*;
;
   logic clk_sys = 0;
   logic sys_rst = 1;
   logic [11:0] mm_addr;
   logic mm_wr, mm_rd, cfg_wr, cfg_rd, ee_present, ee_load, s_valid, s_last;
   logic [31:0] mm_wdata, mm_rdata, cfg_wdata, cfg_rdata, s_data, m_data;
   logic [7:0] cfg_addr, stream_format_code;
   logic [15:0] ee_data;
   logic mm_rvalid, cfg_rvalid, transport_stream_stamp_on, video_cip_stamp_on;
   logic async_tx_pipeline_off, priority_arb_on, phy_accel_notify, s_ready;
   logic m_valid, m_ready, m_last, underrun, retry_pkt, retries_zero, tx_done;
   logic tx_start, store_fwd, stall;
   logic [7:0] fmt [3] = '{8'h20, 8'h00, 8'h7F};
   logic [1:0] stamp [3] = '{2'h2, 2'h1, 2'h0};
   int err_total = 0;
   int n_tests = 0;
   int n_words, base;

   lec_link_enh dut (.*);
   lec_sink u_sink (.*);

   // 250 MHz clock
   always #2 clk_sys = ~clk_sys;

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task hang;
      err_total++;
      summarize;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One access on the memory-mapped (c=0) or config (c=1) port
   task bus(input bit c, input bit w, input logic [11:0] a, input logic [31:0] d);
      tick(1);
      mm_addr = a;
      cfg_addr = a[7:0];
      mm_wdata = d;
      cfg_wdata = d;
      {mm_wr, mm_rd, cfg_wr, cfg_rd} = {w & !c, !w & !c, w & c, !w & c};
      tick(1);
      {mm_wr, mm_rd, cfg_wr, cfg_rd} = 4'h0;
      if (!w)
      begin
         chk(c ? cfg_rvalid : mm_rvalid, 32'h1);
         chk(c ? cfg_rdata : mm_rdata, d);
      end
   endtask

   // Stream n words, valid held high across them
   task push(input int n, input logic l);
      int k;
      tick(1);
      s_valid = 1;
      for (int i = 0; i < n; i++)
      begin
         s_last = l && i == n - 1;
         s_data = 32'(i);
         k = 0;
         while (!s_ready && k < 50)
         begin
            tick(1);
            k++;
         end
         if (k == 50)
            hang;
         tick(1);
      end
      s_valid = 0;
      s_last = 0;
   endtask

   task wait_start;
      int k;
      k = 0;
      while (tx_start !== 1'b1 && k < 40)
      begin
         tick(1);
         k++;
      end
      if (k == 40)
         hang;
      chk(tx_start, 1);
   endtask

   task done_pkt;
      tx_done = 1;
      tick(1);
      tx_done = 0;
   endtask

   // Main sequence
   initial
   begin
      {mm_addr, mm_wr, mm_rd, mm_wdata, cfg_addr, cfg_wr, cfg_rd, cfg_wdata} = '0;
      {ee_present, ee_load, ee_data, stream_format_code, s_valid, s_last, s_data} = '0;
      {underrun, retry_pkt, retries_zero, tx_done, stall} = '0;
      tick(8);
      sys_rst = 0;
      bus(0, 0, 12'hA88, 32'h0000_1000);
      bus(0, 0, 12'hA8C, 32'h0000_1000);
      bus(0, 0, 12'hA90, 32'h0000_0000);
      chk(store_fwd, 0);
      $display("reset test done");
      bus(0, 1, 12'hA88, 32'hFFFF_FFFF);
      bus(0, 0, 12'hA88, 32'h0000_B582);
      bus(1, 0, 12'h0F4, 32'h0000_B582);
      chk({async_tx_pipeline_off, priority_arb_on, phy_accel_notify}, 3'h7);
      bus(0, 1, 12'hA8C, 32'hFFFF_FFFF);
      bus(0, 0, 12'hA8C, 32'h0000_0000);
      bus(1, 1, 12'h0F4, 32'hFFFF_9000);
      bus(0, 1, 12'hA8C, 32'h0000_0000);
      bus(0, 0, 12'hA88, 32'h0000_9000);
      $display("set clear test done");
      bus(0, 1, 12'hA88, 32'h0000_0500);
      for (int i = 0; i < 3; i++)
      begin
         stream_format_code = fmt[i];
         tick(2);
         chk({transport_stream_stamp_on, video_cip_stamp_on}, stamp[i]);
      end
      bus(0, 1, 12'hA8C, 32'h0000_0400);
      stream_format_code = 8'h20;
      tick(2);
      chk({transport_stream_stamp_on, video_cip_stamp_on}, 32'h0);
      $display("stamp test done");
      ee_data = 16'hFFFF;
      ee_present = 1;
      ee_load = 1;
      tick(1);
      ee_load = 0;
      bus(0, 0, 12'hA88, 32'h0000_B582);
      ee_data = 16'h0000;
      ee_present = 0;
      ee_load = 1;
      tick(1);
      ee_load = 0;
      bus(0, 0, 12'hA88, 32'h0000_B582);
      $display("eeprom test done");
      bus(0, 1, 12'hA8C, 32'hFFFF_FFFF);
      bus(0, 1, 12'hA88, 32'h0000_3000);
      push(127, 0);
      tick(6);
      chk(tx_start, 0);
      push(1, 0);
      wait_start;
      done_pkt;
      bus(0, 1, 12'hA8C, 32'h0000_3000);
      tick(2);
      chk(store_fwd, 1);
      push(600, 0);
      tick(6);
      chk(tx_start, 0);
      push(1, 1);
      wait_start;
      done_pkt;
      $display("threshold test done");
      bus(0, 1, 12'hA88, 32'h0000_3000);
      underrun = 1;
      tick(1);
      underrun = 0;
      tick(1);
      chk(store_fwd, 1);
      push(130, 0);
      tick(6);
      chk(tx_start, 0);
      push(1, 1);
      wait_start;
      done_pkt;
      tick(2);
      chk(store_fwd, 0);
      retry_pkt = 1;
      tick(2);
      chk(store_fwd, 1);
      retry_pkt = 0;
      retries_zero = 1;
      tick(2);
      chk(store_fwd, 1);
      retries_zero = 0;
      $display("fallback test done");
      tick(4);
      base = n_words;
      stall = 1;
      tick(2);
      push(3, 1);
      chk(s_ready, 0);
      chk(m_valid, 1);
      chk(m_data, 32'h0);
      stall = 0;
      tick(3);
      chk(m_last, 1);
      chk(m_data, 32'h2);
      tick(5);
      chk(n_words - base, 3);
      bus(0, 1, 12'hA8C, 32'h0000_2000);
      bus(0, 0, 12'hA88, 32'h0000_1000);
      $display("buffer test done");
      summarize;
   end
endmodule
